/* File: core/srcl_pkg.sv */
// package: constants and carrier types for the serial rom config loader
package srcl_pkg;
  // register offsets from control_device_base
  localparam logic [2:0] SRCL_PIN_CTRL_OFFS = 3'h1;
  // pin control field positions
  localparam int SRCL_BIT_CLK = 0;
  localparam int SRCL_BIT_DOUT = 1;
  localparam int SRCL_BIT_SENSE = 2;
  localparam logic [7:0] SRCL_PIN_CTRL_RST = 8'h02;
  // image header
  localparam logic [7:0] SRCL_SIG0 = 8'h55;
  localparam logic [7:0] SRCL_SIG1 = 8'hbb;
  localparam int SRCL_HDR_BYTES = 4;
  localparam int SRCL_CFG_MAX = 384;
  localparam int SRCL_IMG_NOPATCH_MAX = 388;
  localparam int SRCL_ROM_MAX = 2048;
  localparam int SRCL_USER_ID_BITS = 32;
  // memory device address (write form), read adds one
  localparam logic [7:0] SRCL_DEV_ADDR_WR = 8'ha0;
  localparam logic [7:0] SRCL_DEV_ADDR_RD = 8'ha1;
  // serial clock timing
  localparam int SRCL_CLK_HZ = 250_000_000;
  localparam int SRCL_SCL_NS = 10_000;
  localparam int SRCL_QTR_CYC = ((SRCL_CLK_HZ / 1000) * (SRCL_SCL_NS / 4)) / 1_000_000;
  // loaded byte handed to the stream
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] data;
  } srcl_byte_t;
  // host register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } srcl_host_req_t;
endpackage : srcl_pkg

/* File: core/srcl_fifo.sv */
// module: small synchronous fifo with valid/ready on both sides
module srcl_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic full;
  logic empty;
  logic push;
  logic pop;
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty = (wp_q == rp_q);
  assign in_ready_o = !full;
  assign push = in_valid_i && !full;
  assign pop = !empty && (!out_valid_o || out_ready_i);
  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data_i;
    end
  end
  // pointers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
  // registered read port, so output data comes from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o <= mem_q[rp_q[AW-1:0]];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule : srcl_fifo

/* File: core/srcl_loader.sv */
// module: power-on serial rom loader with host bit-bang pin control
// ****************************************************************
// Behaviour
// - present only if bytes are 55h then bbh
// - next two bytes give remaining byte count
// - dummy write address zero, restart, sequential read
// - one memory, single sequential read of image
// - device drives clock; data line shared open-drain
// - config data up to 384 plus header
// - memories up to 2k bytes, patches follow
// - data on data pin zero, clock on address pin zero
// - register bit0 clock, bit1 data out, bit2 sense
// - bit2 one enables host interface, zero disables
// - bit2 reads line; host sets data out first
// - data out bit drives open-drain line
// - new contents load only after device reset
// - image may replace 32 user identifier bits
// ****************************************************************
module srcl_loader
  import srcl_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int QTR_CYC = SRCL_QTR_CYC,
  parameter logic [31:0] DEFAULT_USER_ID = 32'h0000_0000 // arbitrary
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // host register port, same clock
  input wire srcl_pkg::srcl_host_req_t HOST_REQ_I,
  output logic [7:0] HOST_RDATA_O,
  // peripheral pins: data zero open-drain, address zero is the clock
  input wire logic PERIPHERAL_DATA_LINE_ZERO_I,
  output logic PERIPHERAL_DATA_LINE_ZERO_O,
  output logic PERIPHERAL_DATA_LINE_ZERO_OE_O,
  output logic PERIPHERAL_ADDRESS_LINE_ZERO_O,
  // loaded image stream
  output logic CFG_VALID_O,
  input wire logic CFG_READY_I,
  output srcl_pkg::srcl_byte_t CFG_DATA_O,
  // status
  output logic [31:0] USER_ID_O,
  output logic LOAD_DONE_O,
  output logic ROM_PRESENT_O
);
  initial begin
    if (QTR_CYC < 1) $error("quarter clock count must be at least one");
    if (FIFO_DEPTH != 32) $error("loader expects a 32 word fifo");
  end

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  logic sda_s1_q;
  logic sda_s2_q;
  // two flops before any logic reads the shared line
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      sda_s1_q <= PERIPHERAL_DATA_LINE_ZERO_I;
      sda_s2_q <= sda_s1_q;
    end
  end

  // ****************************************************************
  // host pin control register
  // ****************************************************************
  logic [2:0] pin_ctrl_q;
  logic host_en;
  logic host_hit_wr;
  assign host_en = pin_ctrl_q[SRCL_BIT_SENSE];
  assign host_hit_wr = HOST_REQ_I.wr && (HOST_REQ_I.addr == SRCL_PIN_CTRL_OFFS);
  // bits 0..2: clock, data out, enable
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      pin_ctrl_q <= SRCL_PIN_CTRL_RST[2:0];
    end else if (host_hit_wr) begin
      pin_ctrl_q <= HOST_REQ_I.wdata[2:0];
    end
  end
  // read data: bit2 shows the wire, which reads low unless data out released
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      HOST_RDATA_O <= 8'h00;
    end else if (HOST_REQ_I.rd && HOST_REQ_I.addr == SRCL_PIN_CTRL_OFFS) begin
      HOST_RDATA_O <= {5'h00, sda_s2_q, pin_ctrl_q[SRCL_BIT_DOUT],
                       pin_ctrl_q[SRCL_BIT_CLK]};
    end else begin
      HOST_RDATA_O <= 8'h00;
    end
  end

  // ****************************************************************
  // serial engine: quarter-phase bit timer
  // ****************************************************************
  typedef enum {
    SRCL_ST_START, SRCL_ST_DEVW, SRCL_ST_ADDR, SRCL_ST_RESTART, SRCL_ST_DEVR,
    SRCL_ST_READ, SRCL_ST_STOP, SRCL_ST_DONE
  } srcl_state_t;
  srcl_state_t st_q;
  logic [$clog2(QTR_CYC+1)-1:0] qcnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic [11:0] idx_q;
  logic [15:0] len_q;
  logic present_q;
  logic tick;
  logic stalled;
  logic eng_scl_q;
  logic eng_sda_q;
  logic bit_end;
  logic byte_end;
  logic fifo_in_ready;
  logic push_q;
  srcl_byte_t push_data_q;

  assign tick = (qcnt_q == '0);
  // a full fifo holds the serial clock low between bytes, stalling the memory
  assign stalled = push_q && !fifo_in_ready;
  assign bit_end = tick && (ph_q == 2'd3);
  assign byte_end = bit_end && (bit_q == 4'd8);

  logic last_byte;
  logic [7:0] load_byte;
  // the byte that ends the read gets no ack, so the memory lets go before the stop
  assign last_byte = (idx_q == 12'd0 && rx_q != SRCL_SIG0) ||
                     (idx_q == 12'd1 && rx_q != SRCL_SIG1) ||
                     (idx_q == 12'd3 && {len_q[15:8], rx_q} == 16'd0) ||
                     (idx_q >= 12'd4 && (len_q == 16'd1 || idx_q == 12'(SRCL_ROM_MAX - 1)));
  // byte sent once the current state closes; its top bit is set up with the load
  always_comb begin
    load_byte = 8'hff;
    unique case (st_q)
      SRCL_ST_START: load_byte = SRCL_DEV_ADDR_WR;
      SRCL_ST_DEVW: load_byte = 8'h00;
      SRCL_ST_RESTART: load_byte = SRCL_DEV_ADDR_RD;
      SRCL_ST_ADDR, SRCL_ST_DEVR, SRCL_ST_READ, SRCL_ST_STOP, SRCL_ST_DONE: load_byte = 8'hff;
    endcase
  end

  // quarter-period timer
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      qcnt_q <= '0;
    end else if (tick) begin
      qcnt_q <= ($clog2(QTR_CYC+1))'(QTR_CYC - 1);
    end else begin
      qcnt_q <= qcnt_q - 1'b1;
    end
  end

  // phase: 0 low/setup, 1 rise, 2 high/sample, 3 fall
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ph_q <= 2'd0;
    end else if (tick && !stalled && st_q != SRCL_ST_DONE) begin
      ph_q <= ph_q + 2'd1;
    end
  end

  // line drive from engine; start/stop drop or raise data while clock high
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      eng_scl_q <= 1'b1;
      eng_sda_q <= 1'b1;
    end else if (tick && !stalled) begin
      // clock stays high from the stop on, so no stray pulse follows it
      eng_scl_q <= (ph_q == 2'd0) || (ph_q == 2'd1) || (st_q == SRCL_ST_STOP);
      unique case (st_q)
        SRCL_ST_START, SRCL_ST_RESTART: begin
          // high before the rise, low while clock high, first address bit at the close
          eng_sda_q <= (ph_q == 2'd0) || (ph_q == 2'd3 && load_byte[7]);
        end
        SRCL_ST_STOP: begin
          // low under the rising clock, then up while the clock stays high
          eng_sda_q <= (ph_q != 2'd0);
        end
        SRCL_ST_DONE: begin
          eng_sda_q <= 1'b1;
        end
        SRCL_ST_READ: begin
          // ack low except on the closing byte, then low again ahead of the stop
          if (ph_q == 2'd3)
            eng_sda_q <= (bit_q == 4'd7) ? last_byte : (bit_q == 4'd8) ? !last_byte : 1'b1;
        end
        SRCL_ST_DEVW, SRCL_ST_ADDR, SRCL_ST_DEVR: begin
          // next bit set up while the clock is low; ack slot left to the memory
          if (ph_q == 2'd3)
            eng_sda_q <= (bit_q == 4'd8) ? load_byte[7] : (bit_q == 4'd7) ? 1'b1 : sh_q[6];
        end
      endcase
    end
  end

  // bit and shift handling, sample on the high phase
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      bit_q <= 4'd0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
    end else if (tick && !stalled) begin
      if (ph_q == 2'd2 && bit_q < 4'd8)
        rx_q <= {rx_q[6:0], sda_s2_q};
      if (ph_q == 2'd3) begin
        if (st_q == SRCL_ST_START || st_q == SRCL_ST_RESTART || bit_q == 4'd8) begin
          bit_q <= 4'd0;
          sh_q <= load_byte;
        end else begin
          bit_q <= bit_q + 4'd1;
          sh_q <= {sh_q[6:0], 1'b1};
        end
      end
    end
  end

  // ****************************************************************
  // loader sequence
  // ****************************************************************
  // image is walked in a single sequential read
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      st_q <= SRCL_ST_START;
      idx_q <= 12'd0;
      len_q <= 16'd0;
      present_q <= 1'b0;
    end else if (tick && !stalled && ph_q == 2'd3) begin
      unique case (st_q)
        SRCL_ST_START: st_q <= SRCL_ST_DEVW;
        SRCL_ST_DEVW: if (bit_q == 4'd8) st_q <= SRCL_ST_ADDR;
        SRCL_ST_ADDR: if (bit_q == 4'd8) st_q <= SRCL_ST_RESTART; // address zero
        SRCL_ST_RESTART: st_q <= SRCL_ST_DEVR;
        SRCL_ST_DEVR: if (bit_q == 4'd8) st_q <= SRCL_ST_READ;
        SRCL_ST_READ: begin
          if (bit_q == 4'd8) begin
            idx_q <= idx_q + 12'd1;
            unique case (idx_q)
              12'd0: if (rx_q != SRCL_SIG0) st_q <= SRCL_ST_STOP;
              12'd1: begin
                if (rx_q != SRCL_SIG1) st_q <= SRCL_ST_STOP;
                else present_q <= 1'b1;
              end
              12'd2: len_q[15:8] <= rx_q;
              12'd3: begin
                len_q <= {len_q[15:8], rx_q};
                if ({len_q[15:8], rx_q} == 16'd0) st_q <= SRCL_ST_STOP;
              end
              default: begin
                len_q <= len_q - 16'd1;
                // never read past the largest memory size
                if (len_q == 16'd1 || idx_q == 12'(SRCL_ROM_MAX - 1))
                  st_q <= SRCL_ST_STOP;
              end
            endcase
          end
        end
        SRCL_ST_STOP: st_q <= SRCL_ST_DONE;
        SRCL_ST_DONE: st_q <= SRCL_ST_DONE;
      endcase
    end
  end

  // ****************************************************************
  // loaded data: user id and fifo feed
  // ****************************************************************
  logic [31:0] uid_q;
  logic done_q;
  // first four payload bytes replace the user part of the identifier
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      uid_q <= DEFAULT_USER_ID;
    end else if (byte_end && !stalled && st_q == SRCL_ST_READ && idx_q >= 12'd4 &&
                 idx_q < 12'(SRCL_HDR_BYTES + SRCL_USER_ID_BITS / 8)) begin
      uid_q <= {rx_q, uid_q[31:8]};
    end
  end
  // every payload byte goes to the stream, capped at the memory size
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      push_q <= 1'b0;
      push_data_q <= '0;
    end else if (byte_end && !stalled && st_q == SRCL_ST_READ && idx_q >= 12'd4) begin
      push_q <= 1'b1;
      push_data_q <= '{addr: 11'(idx_q - 12'(SRCL_HDR_BYTES)), data: rx_q};
    end else if (fifo_in_ready) begin
      push_q <= 1'b0;
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (st_q == SRCL_ST_DONE) && !push_q;
    end
  end

  srcl_fifo #(
    .WIDTH($bits(srcl_byte_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .in_valid_i(push_q),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_data_q),
    .out_valid_o(CFG_VALID_O),
    .out_ready_i(CFG_READY_I),
    .out_data_o(CFG_DATA_O)
  );

  // ****************************************************************
  // pin outputs: host owns the wires once enabled
  // ****************************************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      PERIPHERAL_ADDRESS_LINE_ZERO_O <= 1'b1;
      PERIPHERAL_DATA_LINE_ZERO_O <= 1'b0;
      PERIPHERAL_DATA_LINE_ZERO_OE_O <= 1'b0;
      USER_ID_O <= 32'h0000_0000;
      LOAD_DONE_O <= 1'b0;
      ROM_PRESENT_O <= 1'b0;
    end else begin
      PERIPHERAL_DATA_LINE_ZERO_O <= 1'b0; // open drain: only ever pulls low
      if (host_en) begin
        PERIPHERAL_ADDRESS_LINE_ZERO_O <= pin_ctrl_q[SRCL_BIT_CLK];
        PERIPHERAL_DATA_LINE_ZERO_OE_O <= !pin_ctrl_q[SRCL_BIT_DOUT];
      end else begin
        PERIPHERAL_ADDRESS_LINE_ZERO_O <= eng_scl_q;
        PERIPHERAL_DATA_LINE_ZERO_OE_O <= !eng_sda_q;
      end
      USER_ID_O <= uid_q;
      LOAD_DONE_O <= done_q;
      ROM_PRESENT_O <= present_q;
    end
  end
endmodule : srcl_loader

/* File: test/srcl_loader_properties.sv */
// checker: port relations of the serial rom config loader
// ****
// checker
// ****
module srcl_chk
  import srcl_pkg::*;
#(
  parameter logic [31:0] DEFAULT_USER_ID = 32'h0
) (
  // clock, reset, host port
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire srcl_pkg::srcl_host_req_t HOST_REQ_I,
  input wire logic [7:0] HOST_RDATA_O,
  // serial pins
  input wire logic PERIPHERAL_DATA_LINE_ZERO_OE_O,
  input wire logic PERIPHERAL_ADDRESS_LINE_ZERO_O,
  // stream and status
  input wire logic CFG_VALID_O,
  input wire logic CFG_READY_I,
  input wire srcl_pkg::srcl_byte_t CFG_DATA_O,
  input wire logic [31:0] USER_ID_O,
  input wire logic LOAD_DONE_O,
  input wire logic ROM_PRESENT_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] reg_q;
  logic [3:0] quiet_q;
  logic [10:0] taken_q;
  logic wr1;
  logic rd1;
  logic scl;
  logic oe;
  // decoded host access and short pin names
  assign wr1 = HOST_REQ_I.wr && HOST_REQ_I.addr == SRCL_PIN_CTRL_OFFS;
  assign rd1 = HOST_REQ_I.rd && HOST_REQ_I.addr == SRCL_PIN_CTRL_OFFS;
  assign scl = PERIPHERAL_ADDRESS_LINE_ZERO_O;
  assign oe = PERIPHERAL_DATA_LINE_ZERO_OE_O;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // mirror of the pin register
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) reg_q <= SRCL_PIN_CTRL_RST[2:0];
    else if (wr1) reg_q <= HOST_REQ_I.wdata[2:0];
  end
  // cycles since the last write, saturating so it never wraps
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || wr1) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  // bytes taken from the stream since reset
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) taken_q <= 11'h000;
    else if (CFG_VALID_O && CFG_READY_I) taken_q <= taken_q + 11'h001;
  end
  AST_HOST_CLK: assert property (
    wr1 && HOST_REQ_I.wdata[2] |-> ##2 scl == $past(HOST_REQ_I.wdata[0], 2))
    else $error("clock pin misses register");
  AST_HOST_OE: assert property (
    wr1 && HOST_REQ_I.wdata[2] |-> ##2 oe == !$past(HOST_REQ_I.wdata[1], 2))
    else $error("drive enable misses register");
  AST_HOST_HOLD: assert property (
    reg_q[2] && quiet_q >= 4'h1 |-> scl == reg_q[0] && oe == !reg_q[1])
    else $error("host pins moved");
  AST_IDLE: assert property (
    !reg_q[2] && quiet_q >= 4'h1 && LOAD_DONE_O |-> scl && !oe)
    else $error("bus not idle after load");
  AST_RD_DATA: assert property (
    rd1 && !HOST_REQ_I.wr |=> HOST_RDATA_O[7:3] == 5'h00 && HOST_RDATA_O[1:0] == $past(reg_q[1:0]))
    else $error("register read wrong");
  AST_RD_ZERO: assert property (
    rd1 && reg_q[2] && !reg_q[1] && quiet_q >= 4'h4 |=> !HOST_RDATA_O[2])
    else $error("line read high while driven low");
  AST_RD_OTHER: assert property (
    !rd1 |=> HOST_RDATA_O == 8'h00)
    else $error("read data without read");
  AST_ADDR_SEQ: assert property (
    CFG_VALID_O |-> CFG_DATA_O.addr == taken_q && ROM_PRESENT_O)
    else $error("stream index out of order");
  AST_STALL: assert property (
    CFG_VALID_O && !CFG_READY_I |=> CFG_VALID_O && $stable(CFG_DATA_O))
    else $error("stream dropped a byte");
  AST_DEFAULTS: assert property (
    LOAD_DONE_O && !ROM_PRESENT_O |-> USER_ID_O == DEFAULT_USER_ID && !CFG_VALID_O)
    else $error("defaults lost on bad image");
  AST_NO_RELOAD: assert property (
    LOAD_DONE_O |=> LOAD_DONE_O && $stable(USER_ID_O) && $stable(ROM_PRESENT_O))
    else $error("load changed without reset");
endmodule : srcl_chk

bind srcl_loader srcl_chk #(.DEFAULT_USER_ID(DEFAULT_USER_ID)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .HOST_REQ_I(HOST_REQ_I),
  .HOST_RDATA_O(HOST_RDATA_O), .PERIPHERAL_DATA_LINE_ZERO_OE_O(PERIPHERAL_DATA_LINE_ZERO_OE_O),
  .PERIPHERAL_ADDRESS_LINE_ZERO_O(PERIPHERAL_ADDRESS_LINE_ZERO_O),
  .CFG_VALID_O(CFG_VALID_O), .CFG_READY_I(CFG_READY_I), .CFG_DATA_O(CFG_DATA_O),
  .USER_ID_O(USER_ID_O), .LOAD_DONE_O(LOAD_DONE_O), .ROM_PRESENT_O(ROM_PRESENT_O)
);

/* File: test/srcl_rom_model.sv */
// partner: behavioural two-wire configuration memory
module srcl_rom_model (
  // bus wires, data is open-drain with a pull-up
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // storage and bit engine
  // ****
  logic [7:0] mem [2048];
  logic [7:0] sh;
  logic [7:0] ob;
  logic [10:0] ptr = 11'h000;
  logic act = 1'b0;
  logic dev;
  logic rd;
  int nb;
  initial sda_low_o = 1'b0;
  // start: data falls while clock high
  always @(negedge sda_i) begin
    if (scl_i) begin
      act = 1'b1;
      dev = 1'b1;
      rd = 1'b0;
      nb = 0;
    end
  end
  // stop releases the bus
  always @(posedge sda_i) begin
    if (scl_i) begin
      act = 1'b0;
      sda_low_o = 1'b0;
    end
  end
  // sample on rising clock; a missing ack from the reader ends the read
  always @(posedge scl_i) begin
    if (act) begin
      if (nb < 8) sh = {sh[6:0], sda_i};
      else if (rd && sda_i) act = 1'b0;
      nb = nb + 1;
    end
  end
  // change data only while the clock is low
  always @(negedge scl_i) begin
    if (act) begin
      sda_low_o = 1'b0;
      if (nb == 8 && !rd) begin
        sda_low_o = 1'b1; // ack each received byte
        if (dev) rd = sh[0];
        else ptr = {3'h0, sh};
        dev = 1'b0;
      end
      if (nb == 9) nb = 0;
      if (rd && nb < 8) begin
        if (nb == 0) begin
          ob = mem[ptr];
          ptr = ptr + 11'h001;
        end
        sda_low_o = !ob[7 - nb];
      end
    end
  end
endmodule : srcl_rom_model

/* File: test/tb_top.sv */
// testbench: loader against the memory model, stream, host pins, reload
module tb_top;
  import srcl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // signals, design and partner
  // ****
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rnd = 1'b0;
  logic rd_pend = 1'b0;
  logic cfg_ready = 1'b0;
  srcl_host_req_t req = '0;
  logic [7:0] rdata;
  logic sda_o, sda_oe, scl, rom_low, cfg_valid, done, present;
  srcl_byte_t cfg_data;
  logic [31:0] uid;
  wire sda;
  srcl_byte_t exp_q[$];
  logic [7:0] rexp_q[$];
  int failures = 0;
  int n_compared = 0;
  int seed = 99;
  logic [31:0] pats = 32'h06050704;
  // open-drain line with pull-up
  assign sda = (sda_o || !sda_oe) && !rom_low;
  always #2 clk = ~clk;
  srcl_loader #(.QTR_CYC(10)) dut (
    .CLK_SYS_I(clk), .RST_I(rst), .HOST_REQ_I(req), .HOST_RDATA_O(rdata),
    .PERIPHERAL_DATA_LINE_ZERO_I(sda), .PERIPHERAL_DATA_LINE_ZERO_O(sda_o),
    .PERIPHERAL_DATA_LINE_ZERO_OE_O(sda_oe), .PERIPHERAL_ADDRESS_LINE_ZERO_O(scl),
    .CFG_VALID_O(cfg_valid), .CFG_READY_I(cfg_ready), .CFG_DATA_O(cfg_data),
    .USER_ID_O(uid), .LOAD_DONE_O(done), .ROM_PRESENT_O(present));
  srcl_rom_model u_rom (.scl_i(scl), .sda_i(sda), .sda_low_o(rom_low));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // one register access; a read notes its expected answer
  // offsets count from a control base the host has already set up
  task automatic host(input logic wr, input logic [2:0] a, input logic [7:0] d);
    if (!wr) rexp_q.push_back(d);
    req = '{wr: wr, rd: !wr, addr: a, wdata: wr ? d : 8'h00};
    @(posedge clk);
    #1 req = '0;
    repeat (5) @(posedge clk); // lets the line settle through the synchroniser
    #1;
  endtask : host
  // ready toggles at random once enabled, otherwise the far side stalls
  always @(posedge clk) begin
    #1 cfg_ready = rnd ? 1'($random(seed)) : 1'b0;
  end
  // monitor: each answer is matched against the oldest note
  always @(posedge clk) begin
    if (rd_pend) check("rdata", rexp_q.pop_front(), rdata);
    rd_pend <= req.rd;
    if (cfg_valid && cfg_ready && exp_q.size() == 0) check("extra byte", 0, 1);
    else if (cfg_valid && cfg_ready) check("cfg byte", exp_q.pop_front(), cfg_data);
  end
  // write an image, reset, let the loader run
  task automatic run_image(input logic [7:0] s0, input logic [7:0] s1, input int stall);
    logic [7:0] b;
    logic good;
    int k;
    good = s0 == SRCL_SIG0 && s1 == SRCL_SIG1;
    rnd = 1'b0;
    u_rom.mem[0] = s0;
    u_rom.mem[1] = s1;
    u_rom.mem[2] = 8'h00; // length, high byte first
    u_rom.mem[3] = 8'h28;
    for (int i = 0; i < 40; i++) begin
      b = 8'($random(seed));
      u_rom.mem[4 + i] = b;
      if (good) exp_q.push_back({11'(i), b});
    end
    rst = 1'b1;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    if (stall > 0) begin
      repeat (stall) @(posedge clk);
      b[0] = scl;
      repeat (200) @(posedge clk);
      #1 check("clock held", b[0], scl);
      check("done early", 0, done);
    end
    rnd = 1'b1;
    for (k = 0; k < 40000 && !(done === 1'b1 && exp_q.size() == 0); k++) @(posedge clk);
    #1 check("present", good, present);
    check("load finished", 1, k < 40000);
    check("left", 0, exp_q.size());
    check("uid", good ? {u_rom.mem[7], u_rom.mem[6], u_rom.mem[5], u_rom.mem[4]} : 0, uid);
    $display("test image %h %h done", s0, s1);
  endtask : run_image
  // main: stalled load, host pin access, bad signatures after reset
  initial begin
    logic [7:0] p;
    run_image(SRCL_SIG0, SRCL_SIG1, 20000);
    host(1'b0, 3'h1, 8'h06);
    for (int i = 0; i < 10; i++) begin
      p = (i < 4) ? pats[8*i +: 8] : {5'h00, 1'b1, 2'($random(seed))};
      host(1'b1, 3'h1, p);
      check("clock pin", p[0], scl);
      check("drive enable", !p[1], sda_oe);
      check("data out pin", 0, sda_o);
      host(1'b0, 3'h1, {5'h00, p[1], p[1], p[0]});
    end
    host(1'b1, 3'h2, 8'h00);
    host(1'b0, 3'h1, {5'h00, p[1], p[1], p[0]});
    host(1'b0, 3'h0, 8'h00);
    host(1'b1, 3'h1, 8'h02);
    check("idle clock", 1, scl);
    check("idle enable", 0, sda_oe);
    $display("test host pins done");
    run_image(8'h00, SRCL_SIG1, 0);
    run_image(SRCL_SIG0, 8'h00, 0);
    tally_and_finish();
  end
  // watchdog against a hung load
  initial begin
    #400000;
    failures++;
    $display("ERROR watchdog expected finish seen timeout");
    tally_and_finish();
  end
endmodule : tb_top
